// [rtl/vie_defs.svh]
// constants for the vectored interrupt block: register indices, fields, resets
// assumes byte address = 4 * index on a 12-bit axi4-lite address
`ifndef VIE_DEFS_SVH
`define VIE_DEFS_SVH
// ----------------------------------------
// register indices
// ----------------------------------------
`define VIE_IDX_STAT 8'h00
`define VIE_IDX_MASK 8'h01
`define VIE_IDX_PINS 8'h02
`define VIE_IDX_CTL 8'h03
`define VIE_IDX_STOPREC 8'h0b
`define VIE_IDX_PRIO 8'hf9
`define VIE_IDX_IRQ 8'hfa
`define VIE_IDX_INTMASK 8'hfb
// ----------------------------------------
// fields and reset values
// ----------------------------------------
`define VIE_NLINES 6
`define VIE_INTMASK_GIE 7
`define VIE_STOPREC_DIV16 0
`define VIE_CTL_CMP 0
`define VIE_ST_HIT 0
`define VIE_ST_VEC 1
`define VIE_RST_8 8'h00
`define VIE_RST_6 6'h00
`define VIE_RST_2 2'h0
`define VIE_PRIO_LINES 3'h6
`define VIE_PRESC_LAST 4'hf
`define VIE_RESP_OKAY 2'h0
`define VIE_RESP_SLVERR 2'h2
`endif

// [rtl/vie_pkg.sv]
// types shared by the vectored interrupt block
// assumes vie_defs.svh supplies the numeric constants
package vie_pkg;
  // ----------------------------------------
  // vector fetch sequencer
  // ----------------------------------------
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_RDLO = 4'b0010,
    ST_RDHI = 4'b0100,
    ST_CAP = 4'b1000
  } vie_state_type;
  // ----------------------------------------
  // carriers
  // ----------------------------------------
  typedef struct packed {
    logic lvd;
    logic t8;
    logic t16;
    logic cmp2;
    logic cmp1;
    logic pin3;
    logic pin2;
    logic pin1;
  } vie_src_type;
  typedef struct packed {
    logic valid;
    logic [2:0] line;
    logic [15:0] addr;
  } vie_vec_type;
endpackage : vie_pkg

// [rtl/vie_prescale.sv]
// divide-by-16 tick for the interrupt logic clock
// assumes div16 is a registered control level
`timescale 1ns/1ps
`include "vie_defs.svh"
module vie_prescale (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // control and tick
  input wire logic div16,
  output logic tick
);
  import vie_pkg::*;
  logic [3:0] cnt_r;
  logic [3:0] cnt_nxt;
  // free-running count; tick every edge unless divided
  assign cnt_nxt = cnt_r + 4'h1;
  assign tick = !div16 || (cnt_r == `VIE_PRESC_LAST);
  always_ff @(posedge aclk) begin
    if (!aresetn) cnt_r <= 4'h0;
    else cnt_r <= cnt_nxt;
  end
endmodule : vie_prescale

// [rtl/vie_edge_sel.sv]
// per-line edge detector with programmable edge for lines 0 and 2
// assumes levels are synchronous to aclk; sampling only on tick
`timescale 1ns/1ps
`include "vie_defs.svh"
module vie_edge_sel (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // sampling
  input wire logic tick,
  input wire logic [5:0] level,
  input wire logic [1:0] esel,
  output logic [5:0] hit
);
  import vie_pkg::*;
  logic [5:0] prev_r;
  // returns {rise_en, fall_en} for a line
  function automatic logic [1:0] edge_mode(input int line, input logic [1:0] sel);
    logic [1:0] m;
    m = 2'b10;
    if (line == 0) m = (sel == 2'b11) ? 2'b11 : (sel[0] ? 2'b10 : 2'b01);
    else if (line == 2) m = (sel == 2'b11) ? 2'b11 : (sel[1] ? 2'b10 : 2'b01);
    else if (line == 1) m = 2'b01;
    return m;
  endfunction : edge_mode
  for (genvar i = 0; i < `VIE_NLINES; i++) begin : g_line
    logic [1:0] md;
    assign md = edge_mode(i, esel);
    assign hit[i] = tick && ((md[1] && level[i] && !prev_r[i]) ||
                             (md[0] && !level[i] && prev_r[i]));
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) prev_r <= `VIE_RST_6;
    else if (tick) prev_r <= level;
  end
endmodule : vie_edge_sel

// [rtl/vie_top.sv]
// vectored interrupt controller with edge select, axi4-lite registers
// assumes one clock, synchronous inputs, program memory with one-cycle read
// What this block does
// - each source's routine address is two program-memory bytes forming 16 bits
// - pending requests are recorded even while masked, for polling
// - first comparator feeds line two, second comparator feeds line zero
// - lines zero and two trigger on rising, falling or both edges
// - edge selection comes from request register bits 7 and 6
// - 00 falling both; 01 line0 rising; 10 line2 rising; 11 both edges
// - software can read the present level of the edge pins
// - global enable changes only by enable/disable instructions and a grant; mask locked while enabled
// - stop-recovery bit 0 divides system and interrupt logic clock by 16
// - stop mode recovery clears the divide-by-16 bit
// - simultaneous requests are resolved by a software-set priority register
// - a grant disables interrupts, fetches the vector and hands it to the core
// - six lines use vector pairs 0,1 through 10,11 in order
//
// The AXI4-Lite slave port was decided locally.
`timescale 1ns/1ps
`include "vie_defs.svh"
module vie_top (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite slave
  input wire logic [11:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [11:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // request sources
  input wire vie_pkg::vie_src_type src,
  input wire logic stop_recovery,
  // processor core
  input wire logic enable_instr,
  input wire logic disable_instr,
  input wire logic int_ack,
  output logic int_req,
  output vie_pkg::vie_vec_type vec,
  output logic sclk_tick,
  // program memory read port
  output logic [15:0] mem_addr,
  output logic mem_rd,
  input wire logic [7:0] mem_rdata,
  // interrupt
  output logic irq
);
  import vie_pkg::*;
  // ----------------------------------------
  // state
  // ----------------------------------------
  logic [7:0] irq_r, intmask_r, stoprec_r, ctl_r, stat_r, mask_r;
  logic [2:0] prio_r, line_r;
  logic [7:0] irq_nxt, intmask_nxt, stat_nxt;
  vie_state_type st_r, st_nxt;
  vie_vec_type vec_r;
  logic [15:0] mem_addr_r;
  logic [7:0] vhi_r;
  logic mem_rd_r, int_req_r, irq_r_out, sclk_r;
  logic aw_full_r, w_full_r, awready_r, wready_r, bvalid_r, arready_r, rvalid_r;
  logic [11:0] aw_addr_r;
  logic [7:0] w_data_r;
  logic w_strb_r;
  logic [1:0] bresp_r, rresp_r;
  logic [31:0] rdata_r;
  function automatic logic is_reg(input logic [11:0] a, input logic [7:0] idx);
    return (a[11:10] == 2'b00) && (a[9:2] == idx);
  endfunction : is_reg
  // rotating search from the programmed start line
  function automatic logic [3:0] pick(input logic [5:0] p, input logic [2:0] start);
    logic [3:0] r;
    logic [2:0] j;
    r = 4'h0;
    for (int k = `VIE_NLINES - 1; k >= 0; k--) begin
      j = 3'((int'(start) + k) % `VIE_NLINES);
      if (p[j]) r = {1'b1, j};
    end
    return r;
  endfunction : pick
  // ----------------------------------------
  // sources and edges
  // ----------------------------------------
  logic [5:0] lvl, hit;
  logic tick, gie, div16;
  assign gie = intmask_r[`VIE_INTMASK_GIE];
  assign div16 = stoprec_r[`VIE_STOPREC_DIV16];
  assign lvl[0] = ctl_r[`VIE_CTL_CMP] ? src.cmp2 : src.pin2;
  assign lvl[1] = src.pin3;
  assign lvl[2] = ctl_r[`VIE_CTL_CMP] ? src.cmp1 : src.pin1;
  assign lvl[3] = src.t16;
  assign lvl[4] = src.t8;
  assign lvl[5] = src.lvd;
  vie_prescale u_presc (
    .aclk(aclk),
    .aresetn(aresetn),
    .div16(div16),
    .tick(tick)
  );
  vie_edge_sel u_edge (
    .aclk(aclk),
    .aresetn(aresetn),
    .tick(tick),
    .level(lvl),
    .esel(irq_r[7:6]),
    .hit(hit)
  );
  // ----------------------------------------
  // axi4-lite decode
  // ----------------------------------------
  logic wr_go, wr_en, map_w, map_r;
  logic w_irq, w_intmask, w_stoprec, w_ctl, w_prio, w_stat, w_mask;
  logic [31:0] rd_mux;
  assign wr_go = aw_full_r && w_full_r && !bvalid_r;
  assign wr_en = wr_go && w_strb_r;
  assign w_irq = wr_en && is_reg(aw_addr_r, `VIE_IDX_IRQ);
  assign w_intmask = wr_en && is_reg(aw_addr_r, `VIE_IDX_INTMASK);
  assign w_stoprec = wr_en && is_reg(aw_addr_r, `VIE_IDX_STOPREC);
  assign w_ctl = wr_en && is_reg(aw_addr_r, `VIE_IDX_CTL);
  assign w_prio = wr_en && is_reg(aw_addr_r, `VIE_IDX_PRIO);
  assign w_stat = wr_en && is_reg(aw_addr_r, `VIE_IDX_STAT);
  assign w_mask = wr_en && is_reg(aw_addr_r, `VIE_IDX_MASK);
  assign map_w = is_reg(aw_addr_r, `VIE_IDX_IRQ) || is_reg(aw_addr_r, `VIE_IDX_INTMASK) ||
                 is_reg(aw_addr_r, `VIE_IDX_STOPREC) || is_reg(aw_addr_r, `VIE_IDX_CTL) ||
                 is_reg(aw_addr_r, `VIE_IDX_PRIO) || is_reg(aw_addr_r, `VIE_IDX_STAT) ||
                 is_reg(aw_addr_r, `VIE_IDX_MASK) || is_reg(aw_addr_r, `VIE_IDX_PINS);
  assign map_r = is_reg(araddr, `VIE_IDX_IRQ) || is_reg(araddr, `VIE_IDX_INTMASK) ||
                 is_reg(araddr, `VIE_IDX_STOPREC) || is_reg(araddr, `VIE_IDX_CTL) ||
                 is_reg(araddr, `VIE_IDX_PRIO) || is_reg(araddr, `VIE_IDX_STAT) ||
                 is_reg(araddr, `VIE_IDX_MASK) || is_reg(araddr, `VIE_IDX_PINS);
  assign rd_mux =
    is_reg(araddr, `VIE_IDX_IRQ) ? {24'h0000_00, irq_r} :
    is_reg(araddr, `VIE_IDX_INTMASK) ? {24'h0000_00, intmask_r} :
    is_reg(araddr, `VIE_IDX_STOPREC) ? {24'h0000_00, stoprec_r} :
    is_reg(araddr, `VIE_IDX_CTL) ? {24'h0000_00, ctl_r} :
    is_reg(araddr, `VIE_IDX_PRIO) ? {29'h0000_0000, prio_r} :
    is_reg(araddr, `VIE_IDX_STAT) ? {24'h0000_00, stat_r} :
    is_reg(araddr, `VIE_IDX_MASK) ? {24'h0000_00, mask_r} :
    is_reg(araddr, `VIE_IDX_PINS) ? {29'h0000_0000, src.pin3, src.pin2, src.pin1} :
    32'h0000_0000;
  // ----------------------------------------
  // grant and vector fetch
  // ----------------------------------------
  logic [3:0] grant;
  logic take, svc;
  logic [5:0] svc_clr;
  assign grant = pick(irq_r[5:0] & intmask_r[5:0], prio_r);
  assign take = (st_r == ST_IDLE) && int_ack && int_req_r && grant[3];
  assign svc = (st_r == ST_CAP);
  assign svc_clr = svc ? 6'(6'h01 << line_r) : `VIE_RST_6;
  always_comb begin
    case (st_r)
      ST_IDLE: st_nxt = take ? ST_RDLO : ST_IDLE;
      ST_RDLO: st_nxt = ST_RDHI;
      ST_RDHI: st_nxt = ST_CAP;
      ST_CAP: st_nxt = ST_IDLE;
      default: st_nxt = ST_IDLE;
    endcase
  end
  // flags: a new edge wins over a software or service clear
  // edge select comes from the captured write word, the bus may have moved on
  assign irq_nxt = {w_irq ? w_data_r[7:6] : irq_r[7:6],
                    ((w_irq ? w_data_r[5:0] : irq_r[5:0]) & ~svc_clr) | hit};
  assign intmask_nxt = {(gie || enable_instr) && !disable_instr && !take,
                        (w_intmask && !gie) ? w_data_r[6:0] : intmask_r[6:0]};
  assign stat_nxt = (stat_r & ~(w_stat ? w_data_r : `VIE_RST_8)) |
                    {6'h00, svc, |hit};
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_r <= `VIE_RST_8;
      intmask_r <= `VIE_RST_8;
      stat_r <= `VIE_RST_8;
    end else begin
      irq_r <= irq_nxt;
      intmask_r <= intmask_nxt;
      stat_r <= stat_nxt;
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      stoprec_r <= `VIE_RST_8;
      ctl_r <= `VIE_RST_8;
      mask_r <= `VIE_RST_8;
      prio_r <= 3'h0;
    end else begin
      if (stop_recovery) stoprec_r[`VIE_STOPREC_DIV16] <= 1'b0;
      else if (w_stoprec) stoprec_r <= w_data_r;
      if (w_ctl) ctl_r <= w_data_r;
      if (w_mask) mask_r <= w_data_r;
      if (w_prio) prio_r <= (w_data_r[2:0] < `VIE_PRIO_LINES) ? w_data_r[2:0] : 3'h0;
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_r <= ST_IDLE;
      line_r <= 3'h0;
      mem_addr_r <= 16'h0000;
      mem_rd_r <= 1'b0;
      vhi_r <= `VIE_RST_8;
      vec_r <= '0;
    end else begin
      st_r <= st_nxt;
      vec_r.valid <= svc;
      mem_rd_r <= take || (st_r == ST_RDLO);
      if (take) begin
        line_r <= grant[2:0];
        mem_addr_r <= {12'h000, grant[2:0], 1'b0};
      end
      if (st_r == ST_RDLO) mem_addr_r <= mem_addr_r + 16'h0001;
      if (st_r == ST_RDHI) vhi_r <= mem_rdata;
      if (svc) vec_r.addr <= {vhi_r, mem_rdata};
      if (svc) vec_r.line <= line_r;
    end
  end
  // ----------------------------------------
  // core request, clock tick, interrupt output
  // ----------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      int_req_r <= 1'b0;
      sclk_r <= 1'b1;
      irq_r_out <= 1'b0;
    end else begin
      int_req_r <= intmask_nxt[`VIE_INTMASK_GIE] && (st_nxt == ST_IDLE) &&
                   |(irq_nxt[5:0] & intmask_nxt[5:0]);
      sclk_r <= tick;
      irq_r_out <= |(stat_nxt & mask_r);
    end
  end
  // ----------------------------------------
  // axi4-lite handshakes
  // ----------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      {aw_full_r, w_full_r, bvalid_r, rvalid_r} <= 4'h0;
      {awready_r, wready_r, arready_r} <= 3'h7;
      aw_addr_r <= 12'h000;
      w_data_r <= `VIE_RST_8;
      w_strb_r <= 1'b0;
      bresp_r <= `VIE_RESP_OKAY;
      rresp_r <= `VIE_RESP_OKAY;
      rdata_r <= 32'h0000_0000;
    end else begin
      if (awvalid && awready_r) begin
        aw_addr_r <= awaddr;
        aw_full_r <= 1'b1;
        awready_r <= 1'b0;
      end
      if (wvalid && wready_r) begin
        w_data_r <= wdata[7:0];
        w_strb_r <= wstrb[0];
        w_full_r <= 1'b1;
        wready_r <= 1'b0;
      end
      if (wr_go) begin
        {aw_full_r, w_full_r} <= 2'b00;
        bvalid_r <= 1'b1;
        bresp_r <= map_w ? `VIE_RESP_OKAY : `VIE_RESP_SLVERR;
      end
      if (bvalid_r && bready) begin
        bvalid_r <= 1'b0;
        {awready_r, wready_r} <= 2'b11;
      end
      if (arvalid && arready_r) begin
        arready_r <= 1'b0;
        rvalid_r <= 1'b1;
        rdata_r <= rd_mux;
        rresp_r <= map_r ? `VIE_RESP_OKAY : `VIE_RESP_SLVERR;
      end
      if (rvalid_r && rready) begin
        rvalid_r <= 1'b0;
        arready_r <= 1'b1;
      end
    end
  end
  assign {awready, wready, bvalid, bresp} = {awready_r, wready_r, bvalid_r, bresp_r};
  assign {arready, rvalid, rdata, rresp} = {arready_r, rvalid_r, rdata_r, rresp_r};
  assign {int_req, vec, sclk_tick, irq} = {int_req_r, vec_r, sclk_r, irq_r_out};
  assign {mem_addr, mem_rd} = {mem_addr_r, mem_rd_r};
  // ----------------------------------------
  // assertions
  // ----------------------------------------
  property p_vec_fetch;
    @(posedge aclk) disable iff (!aresetn)
      st_r == ST_CAP |=> vec.valid && vec.addr == {$past(mem_rdata, 2), $past(mem_rdata)};
  endproperty
  a_vec_fetch: assert property (p_vec_fetch) else $error("vector not two fetched bytes");
  property p_masked_pend;
    @(posedge aclk) disable iff (!aresetn)
      hit[3] && !intmask_r[3] |=> irq_r[3] && !int_req;
  endproperty
  a_masked_pend: assert property (p_masked_pend) else $error("masked request lost");
  property p_cmp_route;
    @(posedge aclk) disable iff (!aresetn)
      ctl_r[0] && !div16 && irq_r[7:6] == 2'b11 && src.cmp1 != $past(src.cmp1)
      |=> irq_r[2];
  endproperty
  a_cmp_route: assert property (p_cmp_route) else $error("comparator not on line 2");
  property p_esel_rise0;
    @(posedge aclk) disable iff (!aresetn)
      !div16 && irq_r[7:6] == 2'b01 && !ctl_r[0] && $rose(src.pin2) |=> irq_r[0];
  endproperty
  a_esel_rise0: assert property (p_esel_rise0) else $error("line 0 rise missed");
  property p_mask_lock;
    @(posedge aclk) disable iff (!aresetn)
      gie && w_intmask |=> intmask_r[6:0] == $past(intmask_r[6:0]);
  endproperty
  a_mask_lock: assert property (p_mask_lock) else $error("mask changed while enabled");
  // cycles since the last tick while divided; a long repetition would be unrolled
  logic [3:0] gap_r;
  logic gap_seen_r;
  always_ff @(posedge aclk) begin
    if (!aresetn || !div16) begin
      gap_r <= 4'h0;
      gap_seen_r <= 1'b0;
    end else begin
      gap_r <= tick ? 4'h0 : gap_r + 4'h1;
      gap_seen_r <= gap_seen_r || tick;
    end
  end
  property p_div16;
    @(posedge aclk) disable iff (!aresetn)
      div16 && gap_seen_r |-> tick == (gap_r == `VIE_PRESC_LAST);
  endproperty
  a_div16: assert property (p_div16) else $error("divide by 16 period wrong");
  property p_stop_clr;
    @(posedge aclk) disable iff (!aresetn)
      stop_recovery |=> !stoprec_r[`VIE_STOPREC_DIV16];
  endproperty
  a_stop_clr: assert property (p_stop_clr) else $error("div16 kept after recovery");
  property p_grant;
    @(posedge aclk) disable iff (!aresetn)
      take |=> !gie && mem_rd && mem_addr == {12'h000, line_r, 1'b0} ##3 vec.valid;
  endproperty
  a_grant: assert property (p_grant) else $error("interrupt cycle wrong");
  property p_sticky;
    @(posedge aclk) disable iff (!aresetn)
      irq_r[4] && !w_irq && !(svc && line_r == 3'h4) |=> irq_r[4];
  endproperty
  a_sticky: assert property (p_sticky) else $error("flag dropped unserviced");
endmodule : vie_top

// [dv/vie_core_model.sv]
// core and program memory partner for the vectored interrupt block
// assumes one aclk domain; memory answers in the cycle after mem_rd
`timescale 1ns/1ps
module vie_core_model (
  // clock
  input wire logic aclk,
  // core link
  input wire logic int_req,
  input wire logic [1:0] ack_dly,
  output logic int_ack,
  // program memory
  input wire logic [15:0] mem_addr,
  input wire logic mem_rd,
  output logic [7:0] mem_rdata
);
  // ----------------------------------------
  // behaviour
  // ----------------------------------------
  logic [1:0] wait_r;
  initial begin
    int_ack = 1'b0;
    mem_rdata = 8'h00;
    wait_r = 2'h0;
  end
  // vector bytes; an idle bus toggles so stale data never looks right
  always @(posedge aclk) begin
    if (mem_rd) begin
      mem_rdata <= {mem_addr[3:0], ~mem_addr[3:0]};
    end else begin
      mem_rdata <= ~mem_rdata;
    end
  end
  // accept after a chosen wait, one pulse per request
  always @(posedge aclk) begin
    if (int_req && !int_ack && wait_r == ack_dly) begin
      int_ack <= 1'b1;
      wait_r <= 2'h0;
    end else begin
      int_ack <= 1'b0;
      wait_r <= (int_req && !int_ack) ? wait_r + 2'h1 : 2'h0;
    end
  end
endmodule : vie_core_model

// [dv/tb_top.sv]
// self-checking bench for the vectored interrupt block
// assumes the core model partner and byte address = 4 * register index
`timescale 1ns/1ps
`include "vie_defs.svh"
module tb_top;
  import vie_pkg::*;
  localparam logic [11:0] A_STAT = {2'b00, `VIE_IDX_STAT, 2'b00};
  localparam logic [11:0] A_MASK = {2'b00, `VIE_IDX_MASK, 2'b00};
  localparam logic [11:0] A_PINS = {2'b00, `VIE_IDX_PINS, 2'b00};
  localparam logic [11:0] A_CTL = {2'b00, `VIE_IDX_CTL, 2'b00};
  localparam logic [11:0] A_STOPREC = {2'b00, `VIE_IDX_STOPREC, 2'b00};
  localparam logic [11:0] A_PRIO = {2'b00, `VIE_IDX_PRIO, 2'b00};
  localparam logic [11:0] A_IRQ = {2'b00, `VIE_IDX_IRQ, 2'b00};
  localparam logic [11:0] A_INTMASK = {2'b00, `VIE_IDX_INTMASK, 2'b00};
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid;
  logic stop_recovery, enable_instr, disable_instr, int_ack, int_req, sclk_tick, mem_rd, irq;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb, v;
  logic [1:0] bresp, rresp, last_resp, ack_dly, e;
  logic [15:0] mem_addr;
  logic [7:0] mem_rdata;
  vie_src_type src;
  vie_vec_type vec;
  int num_errors = 0;
  int checks = 0;
  int m_pend, p, l, n;
  logic [11:0] regs [7] = '{A_STAT, A_MASK, A_CTL, A_STOPREC, A_PRIO, A_IRQ, A_INTMASK};
  // ----------------------------------------
  // design, partner, clock
  // ----------------------------------------
  vie_top uut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .src(src), .stop_recovery(stop_recovery), .enable_instr(enable_instr),
    .disable_instr(disable_instr), .int_ack(int_ack), .int_req(int_req), .vec(vec),
    .sclk_tick(sclk_tick), .mem_addr(mem_addr), .mem_rd(mem_rd), .mem_rdata(mem_rdata),
    .irq(irq));
  vie_core_model core (.aclk(aclk), .int_req(int_req), .ack_dly(ack_dly), .int_ack(int_ack),
    .mem_addr(mem_addr), .mem_rd(mem_rd), .mem_rdata(mem_rdata));
  always #2 aclk = ~aclk;
  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task end_of_test;
    $display("checks %0d num_errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : end_of_test
  task timeout(input string nm);
    num_errors++;
    $display("wrong value %s expected answer seen none", nm);
    end_of_test();
  endtask : timeout
  // valids are dropped only at the edge that takes them
  task axw(input logic [11:0] a, input logic [7:0] d, input logic [3:0] s = 4'h1);
    int k;
    @(posedge aclk);
    awaddr <= a;
    wdata <= {24'h00_0000, d};
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (k = 0; k < 64; k++) begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    last_resp = bresp;
    bready <= 1'b0;
    if (k == 64) timeout("bvalid");
  endtask : axw
  task rdchk(input string nm, input logic [11:0] a, input logic [7:0] x);
    int k;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (k = 0; k < 64; k++) begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    last_resp = rresp;
    rready <= 1'b0;
    if (k == 64) timeout("rvalid");
    chk(nm, rdata, {24'h00_0000, x});
  endtask : rdchk
  task settle;
    repeat (6) @(posedge aclk);
  endtask : settle
  task instr(input bit en);
    @(posedge aclk);
    if (en) enable_instr <= 1'b1;
    else disable_instr <= 1'b1;
    @(posedge aclk);
    enable_instr <= 1'b0;
    disable_instr <= 1'b0;
  endtask : instr
  task ticks(input int cyc, input int exp);
    n = 0;
    repeat (cyc) begin
      @(posedge aclk);
      if (sclk_tick === 1'b1) n++;
    end
    chk("ticks", n, exp);
  endtask : ticks
  // rotating priority: first pending line at or after pr
  function automatic int pick(input int pend, input int pr);
    for (int i = 0; i < 6; i++) begin
      if (pend[(pr + i) % 6]) return (pr + i) % 6;
    end
    return 0;
  endfunction : pick
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  initial begin
    repeat (90000) @(posedge aclk);
    timeout("run");
  end
  initial begin
    aclk = 1'b0;
    aresetn = 1'b0;
    {awaddr, araddr, wdata, wstrb} = '0;
    {awvalid, wvalid, bready, arvalid, rready} = '0;
    {stop_recovery, enable_instr, disable_instr} = '0;
    ack_dly = 2'h0;
    src = 8'h04;
    p = $urandom(66091);
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    foreach (regs[i]) rdchk("reset", regs[i], 8'h00);
    chk("read resp", last_resp, `VIE_RESP_OKAY);
    rdchk("unmapped", 12'h100, 8'h00);
    chk("unmapped resp", last_resp, `VIE_RESP_SLVERR);
    axw(12'h100, 8'h55);
    chk("unmapped wr resp", last_resp, `VIE_RESP_SLVERR);
    // masked flags still record the chosen edges
    for (int i = 0; i < 4; i++) begin
      e = i[1:0];
      axw(A_IRQ, {e, 6'h00});
      src.pin1 <= 1'b1;
      src.pin2 <= 1'b1;
      settle();
      rdchk("rise", A_IRQ, {e, 3'b000, e[1], 1'b0, e[0]});
      rdchk("pins", A_PINS, 8'h07);
      axw(A_IRQ, {e, 6'h00});
      src.pin1 <= 1'b0;
      src.pin2 <= 1'b0;
      settle();
      rdchk("fall", A_IRQ, {e, 3'b000, ~e[1] | e[0], 1'b0, ~e[0] | e[1]});
    end
    axw(A_IRQ, 8'hc0);
    src.pin3 <= 1'b0;
    src.t16 <= 1'b1;
    src.t8 <= 1'b1;
    src.lvd <= 1'b1;
    settle();
    rdchk("lines", A_IRQ, 8'hfa);
    rdchk("stat", A_STAT, 8'h01);
    chk("irq masked", irq, 1'b0);
    axw(A_MASK, 8'h01);
    settle();
    chk("irq", irq, 1'b1);
    axw(A_STAT, 8'h01);
    settle();
    chk("irq clear", irq, 1'b0);
    axw(A_CTL, 8'h01);
    axw(A_IRQ, 8'hc0);
    src.cmp1 <= 1'b1;
    settle();
    rdchk("cmp1", A_IRQ, 8'hc4);
    axw(A_IRQ, 8'hc0);
    src.cmp2 <= 1'b1;
    settle();
    rdchk("cmp2", A_IRQ, 8'hc1);
    // vectored grants drain all six lines under random priority
    instr(1'b0);
    axw(A_INTMASK, 8'h3f);
    axw(A_IRQ, 8'h3f);
    m_pend = 'h3f;
    for (int i = 0; i < 6; i++) begin
      p = $urandom_range(5);
      ack_dly <= 2'($urandom);
      axw(A_PRIO, p[7:0]);
      l = pick(m_pend, p);
      m_pend[l] = 1'b0;
      v = 4'(2 * l);
      instr(1'b1);
      for (n = 0; n < 100 && vec.valid !== 1'b1; n++) @(posedge aclk);
      if (n == 100) timeout("vec");
      chk("line", vec.line, l);
      chk("addr", vec.addr, {v, ~v, v + 4'h1, ~(v + 4'h1)});
      rdchk("pend", A_IRQ, 8'(m_pend));
      rdchk("gie", A_INTMASK, 8'h3f);
    end
    rdchk("stat vec", A_STAT, 8'h03);
    axw(A_PRIO, 8'h07);
    rdchk("prio", A_PRIO, 8'h00);
    axw(A_INTMASK, 8'h80);
    rdchk("mask reg", A_INTMASK, 8'h00);
    axw(A_INTMASK, 8'h3f);
    instr(1'b1);
    axw(A_INTMASK, 8'h00);
    rdchk("mask lock", A_INTMASK, 8'hbf);
    instr(1'b0);
    // divider select and its clearing on stop recovery
    axw(A_STOPREC, 8'h01, 4'h0);
    rdchk("strobe", A_STOPREC, 8'h00);
    axw(A_STOPREC, 8'h01);
    chk("write resp", last_resp, `VIE_RESP_OKAY);
    rdchk("div sel", A_STOPREC, 8'h01);
    repeat (2) @(posedge aclk);
    ticks(64, 4);
    stop_recovery <= 1'b1;
    @(posedge aclk);
    stop_recovery <= 1'b0;
    rdchk("div clear", A_STOPREC, 8'h00);
    ticks(16, 16);
    end_of_test();
  end
endmodule : tb_top
